// *** src/ats_pkg.sv ***
package ats_pkg;

	// ----------------------------------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [7:0] ATS_IDX_CFG    = 8'h0f;
	localparam logic [7:0] ATS_IDX_AOFFS  = 8'h10;
	localparam logic [7:0] ATS_IDX_RESULT = 8'h11;
	localparam logic [7:0] ATS_IDX_TCAL   = 8'h12;
	localparam logic [7:0] ATS_IDX_TOFS   = 8'h13;
	localparam logic [7:0] ATS_IDX_IRQ_ST = 8'h20;
	localparam logic [7:0] ATS_IDX_IRQ_EN = 8'h21;
	localparam logic [7:0] ATS_IDX_IRQ_CL = 8'h22;
	localparam int         ATS_ADDR_W     = 12;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int         ATS_CFG_START  = 7;
	localparam logic [7:0] ATS_RST_CFG    = 8'h00;
	localparam logic [3:0] ATS_RST_AOFFS  = 4'h0;
	localparam logic [7:0] ATS_RST_RESULT = 8'h00;
	localparam logic [7:0] ATS_RST_TCAL   = 8'h20;
	localparam logic [7:0] ATS_RST_TOFS   = 8'h00;
	localparam int         ATS_IRQ_W      = 2;
	localparam int         ATS_EV_DONE    = 0;
	localparam int         ATS_EV_RESTART = 1;

	// ----------------------------------------------------------------
	// source, reference and scale codes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ATS_SRC_TEMP  = 3'h0,
		ATS_SRC_PIN0  = 3'h1,
		ATS_SRC_PIN1  = 3'h2,
		ATS_SRC_PIN2  = 3'h3,
		ATS_SRC_D01   = 3'h4,
		ATS_SRC_D12   = 3'h5,
		ATS_SRC_D02   = 3'h6,
		ATS_SRC_GND   = 3'h7
	} ats_src_t;

	localparam logic [1:0] ATS_REF_THIRD  = 2'h2;
	localparam logic [1:0] ATS_REF_HALF   = 2'h3;
	localparam logic [6:0] ATS_FS_STEP_LO = 7'h0e;
	localparam logic [6:0] ATS_FS_STEP_HI = 7'h15;

	// ----------------------------------------------------------------
	// bus responses and sequencer states
	// ----------------------------------------------------------------
	localparam logic [1:0] ATS_RESP_OKAY  = 2'h0;
	localparam logic [1:0] ATS_RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		ATS_IDLE = 1'b0,
		ATS_CONV = 1'b1
	} ats_state_t;

endpackage

// *** src/ats_temp_offset.sv ***
`timescale 1ns/1ns
module ats_temp_offset (
	input  wire logic       apply,
	input  wire logic [7:0] raw,
	input  wire logic [7:0] offset,
	output logic      [7:0] result
);
	import ats_pkg::*;

	logic signed [9:0] sum;

	// ----------------------------------------------------------------
	// signed offset added to the temperature code, saturated
	// ----------------------------------------------------------------
	always_comb begin
		sum = $signed({2'b00, raw}) + $signed({{2{offset[7]}}, offset});
		if (!apply) begin
			result = raw;
		end else if (sum < 0) begin
			result = 8'h00;
		end else if (sum > 10'sh0ff) begin
			result = 8'hff;
		end else begin
			result = sum[7:0];
		end
	end

endmodule

// *** src/ats_adc_ctrl.sv ***
`timescale 1ns/1ns
module ats_adc_ctrl #(
	parameter int CONV_CYCLES = 20
) (
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic [ats_pkg::ATS_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [ats_pkg::ATS_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic [7:0]                    raw_sample,
	output logic                               irq,
	output logic                               conv_busy,
	output logic                               src_temp,
	output logic [2:0]                         src_pin_pos,
	output logic [2:0]                         src_pin_neg,
	output logic                               src_gnd,
	output logic                               ref_bandgap,
	output logic                               ref_vdd_third,
	output logic                               ref_vdd_half,
	output logic [6:0]                         fs_milli_vdd,
	output logic signed [3:0]                  amp_offset_milli,
	output logic [1:0]                         ts_range,
	output logic                               ts_kelvin_offset_en,
	output logic [3:0]                         ts_trim
);
	import ats_pkg::*;

	localparam int CNT_W = $clog2(CONV_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);

	typedef struct packed {
		ats_state_t           state;
		logic [CNT_W-1:0]     cnt;
		logic                 done;
		logic                 busy;
		logic [2:0]           sel;
		logic [1:0]           refs;
		logic [1:0]           gain;
		logic [3:0]           aoffs;
		logic [7:0]           result;
		logic [7:0]           tcal;
		logic [7:0]           tofs;
		logic [ATS_IRQ_W-1:0] irq_st;
		logic [ATS_IRQ_W-1:0] irq_en;
		logic                 irq;
		logic                 aw_have;
		logic [7:0]           aw_idx;
		logic                 w_have;
		logic [7:0]           w_data;
		logic                 w_lane0;
		logic                 awready;
		logic                 wready;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 arready;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
		logic                 src_temp;
		logic [2:0]           pin_pos;
		logic [2:0]           pin_neg;
		logic                 src_gnd;
		logic                 ref_bg;
		logic                 ref_third;
		logic                 ref_half;
		logic [6:0]           fs;
		logic signed [3:0]    aoffs_s;
		logic [3:0]           trim;
	} ats_regs_t;

	ats_regs_t  q;
	ats_regs_t  d;
	logic [7:0] temp_adj;
	logic [7:0] ar_idx;
	logic       wr_fire;
	logic       start_wr;
	logic [ATS_IRQ_W-1:0] ev;

	// ----------------------------------------------------------------
	// temperature value offset
	// ----------------------------------------------------------------
	ats_temp_offset u_toffs (
		.apply  (q.sel == ATS_SRC_TEMP),
		.raw    (raw_sample),
		.offset (q.tofs),
		.result (temp_adj)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d        = q;
		ev       = '0;
		ar_idx   = s_axi_araddr[ATS_ADDR_W-1:2] > 10'h0ff ? 8'hff : s_axi_araddr[9:2];
		wr_fire  = 1'b0;
		start_wr = 1'b0;

		// write address and data, taken in either order
		if (s_axi_awvalid && q.awready) begin
			d.aw_have = 1'b1;
			d.awready = 1'b0;
			d.aw_idx  = s_axi_awaddr[ATS_ADDR_W-1:2] > 10'h0ff ? 8'hff : s_axi_awaddr[9:2];
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_have  = 1'b1;
			d.wready  = 1'b0;
			d.w_data  = s_axi_wdata[7:0];
			d.w_lane0 = s_axi_wstrb[0];
		end
		if (q.aw_have && q.w_have && !q.bvalid) begin
			wr_fire   = 1'b1;
			d.aw_have = 1'b0;
			d.w_have  = 1'b0;
			d.bvalid  = 1'b1;
			d.bresp   = ATS_RESP_OKAY;
			case (q.aw_idx)
				ATS_IDX_CFG, ATS_IDX_AOFFS, ATS_IDX_RESULT, ATS_IDX_TCAL,
				ATS_IDX_TOFS, ATS_IDX_IRQ_ST, ATS_IDX_IRQ_EN, ATS_IDX_IRQ_CL: begin
					d.bresp = ATS_RESP_OKAY;
				end
				default: begin
					d.bresp = ATS_RESP_SLVERR;
				end
			endcase
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid  = 1'b0;
			d.awready = 1'b1;
			d.wready  = 1'b1;
		end

		// register writes
		if (wr_fire && q.w_lane0) begin
			case (q.aw_idx)
				ATS_IDX_CFG: begin
					d.sel      = q.w_data[6:4];
					d.refs     = q.w_data[3:2];
					d.gain     = q.w_data[1:0];
					start_wr   = q.w_data[ATS_CFG_START];
				end
				ATS_IDX_AOFFS: begin
					d.aoffs = q.w_data[3:0];
				end
				ATS_IDX_TCAL: begin
					d.tcal = q.w_data;
				end
				ATS_IDX_TOFS: begin
					d.tofs = q.w_data;
				end
				ATS_IDX_IRQ_EN: begin
					d.irq_en = q.w_data[ATS_IRQ_W-1:0];
				end
				ATS_IDX_RESULT: begin
					d.result = q.result;
				end
				default: begin
					d.tofs = d.tofs;
				end
			endcase
		end

		// conversion sequencer
		case (q.state)
			ATS_IDLE: begin
				d.cnt = '0;
			end
			ATS_CONV: begin
				d.cnt = q.cnt + CNT_W'(1);
				if (q.cnt == CNT_LAST) begin
					d.state  = ATS_IDLE;
					d.done   = 1'b1;
					d.result = temp_adj;
					ev[ATS_EV_DONE] = 1'b1;
				end
			end
			default: begin
				d.state = ATS_IDLE;
			end
		endcase
		if (start_wr) begin
			if (q.state == ATS_CONV) begin
				ev[ATS_EV_RESTART] = 1'b1;
			end
			d.state  = ATS_CONV;
			d.cnt    = '0;
			d.done   = 1'b0;
			ev[ATS_EV_DONE] = 1'b0;
		end

		// sticky events, set wins over clear
		if (wr_fire && q.w_lane0 && q.aw_idx == ATS_IDX_IRQ_CL) begin
			d.irq_st = q.irq_st & ~q.w_data[ATS_IRQ_W-1:0];
		end
		d.irq_st = d.irq_st | ev;
		d.irq    = |(d.irq_st & d.irq_en);

		// reads
		if (s_axi_arvalid && q.arready) begin
			d.arready = 1'b0;
			d.rvalid  = 1'b1;
			d.rresp   = ATS_RESP_OKAY;
			d.rdata   = '0;
			case (ar_idx)
				ATS_IDX_CFG:    d.rdata[7:0] = {q.done, q.sel, q.refs, q.gain};
				ATS_IDX_AOFFS:  d.rdata[7:0] = {4'h0, q.aoffs};
				ATS_IDX_RESULT: d.rdata[7:0] = q.result;
				ATS_IDX_TCAL:   d.rdata[7:0] = q.tcal;
				ATS_IDX_TOFS:   d.rdata[7:0] = q.tofs;
				ATS_IDX_IRQ_ST: d.rdata[ATS_IRQ_W-1:0] = q.irq_st;
				ATS_IDX_IRQ_EN: d.rdata[ATS_IRQ_W-1:0] = q.irq_en;
				ATS_IDX_IRQ_CL: d.rdata = '0;
				default:        d.rresp = ATS_RESP_SLVERR;
			endcase
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid  = 1'b0;
			d.arready = 1'b1;
		end

		// analog control outputs
		d.src_temp = 1'b0;
		d.pin_pos  = 3'h0;
		d.pin_neg  = 3'h0;
		d.src_gnd  = 1'b0;
		case (d.sel)
			ATS_SRC_TEMP: d.src_temp = 1'b1;
			ATS_SRC_PIN0: d.pin_pos  = 3'h1;
			ATS_SRC_PIN1: d.pin_pos  = 3'h2;
			ATS_SRC_PIN2: d.pin_pos  = 3'h4;
			ATS_SRC_D01: begin
				d.pin_pos = 3'h1;
				d.pin_neg = 3'h2;
			end
			ATS_SRC_D12: begin
				d.pin_pos = 3'h2;
				d.pin_neg = 3'h4;
			end
			ATS_SRC_D02: begin
				d.pin_pos = 3'h1;
				d.pin_neg = 3'h4;
			end
			default: d.src_gnd = 1'b1;
		endcase
		d.ref_third = (d.refs == ATS_REF_THIRD);
		d.ref_half  = (d.refs == ATS_REF_HALF);
		d.ref_bg    = !d.refs[1];
		d.fs = (d.refs[0] ? ATS_FS_STEP_HI : ATS_FS_STEP_LO) * {5'h00, d.gain + 2'h1};
		if (d.gain == 2'h3) begin
			d.fs = d.refs[0] ? 7'(ATS_FS_STEP_HI * 4) : 7'(ATS_FS_STEP_LO * 4);
		end
		d.aoffs_s = d.aoffs[3] ? -$signed({1'b0, d.aoffs[2:0]}) : $signed({1'b0, d.aoffs[2:0]});
		d.trim    = d.tcal[4] ? d.tcal[3:0] : 4'h0;
		d.busy    = (d.state == ATS_CONV);

		// synchronous reset
		if (!resetn) begin
			d         = '0;
			d.state   = ATS_IDLE;
			d.sel     = ATS_RST_CFG[6:4];
			d.refs    = ATS_RST_CFG[3:2];
			d.gain    = ATS_RST_CFG[1:0];
			d.aoffs   = ATS_RST_AOFFS;
			d.result  = ATS_RST_RESULT;
			d.tcal    = ATS_RST_TCAL;
			d.tofs    = ATS_RST_TOFS;
			d.done    = 1'b0;
			d.awready = 1'b1;
			d.wready  = 1'b1;
			d.arready = 1'b1;
			d.src_temp = 1'b1;
			d.ref_bg  = 1'b1;
			d.fs      = ATS_FS_STEP_LO;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		q <= d;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready       = q.awready;
	assign s_axi_wready        = q.wready;
	assign s_axi_bresp         = q.bresp;
	assign s_axi_bvalid        = q.bvalid;
	assign s_axi_arready       = q.arready;
	assign s_axi_rdata         = q.rdata;
	assign s_axi_rresp         = q.rresp;
	assign s_axi_rvalid        = q.rvalid;
	assign irq                 = q.irq;
	assign conv_busy           = q.busy;
	assign src_temp            = q.src_temp;
	assign src_pin_pos         = q.pin_pos;
	assign src_pin_neg         = q.pin_neg;
	assign src_gnd             = q.src_gnd;
	assign ref_bandgap         = q.ref_bg;
	assign ref_vdd_third       = q.ref_third;
	assign ref_vdd_half        = q.ref_half;
	assign fs_milli_vdd        = q.fs;
	assign amp_offset_milli    = q.aoffs_s;
	assign ts_range            = q.tcal[7:6];
	assign ts_kelvin_offset_en = q.tcal[5];
	assign ts_trim             = q.trim;

endmodule

// *** tb/ats_adc_ctrl_asserts.sv ***
`timescale 1ns/1ns
module ats_adc_ctrl_chk #(
	parameter int CONV_CYCLES = 20
) (
	input wire logic              clk,
	input wire logic              resetn,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              irq,
	input wire logic              conv_busy,
	input wire logic              src_temp,
	input wire logic [2:0]        src_pin_pos,
	input wire logic              src_gnd,
	input wire logic              ref_bandgap,
	input wire logic              ref_vdd_third,
	input wire logic              ref_vdd_half,
	input wire logic [6:0]        fs_milli_vdd,
	input wire logic signed [3:0] amp_offset_milli,
	input wire logic [3:0]        ts_trim,
	input wire logic              ts_kelvin_offset_en
);
	// ----
	// busy cycle count
	// ----
	logic [15:0] n_q;
	always_ff @(posedge clk) n_q <= conv_busy ? n_q + 16'h1 : 16'h0;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_len;
		$fell(conv_busy) |-> n_q >= CONV_CYCLES;
	endproperty
	a_len: assert property (p_len) else $error("conversion too short");
	property p_src;
		$onehot({src_temp, src_gnd, |src_pin_pos});
	endproperty
	a_src: assert property (p_src) else $error("source not one-hot");
	property p_ref;
		$onehot({ref_bandgap, ref_vdd_third, ref_vdd_half});
	endproperty
	a_ref: assert property (p_ref) else $error("reference not one-hot");
	property p_fs;
		ref_vdd_half |-> fs_milli_vdd inside {7'h15, 7'h2a, 7'h3f, 7'h54};
	endproperty
	a_fs: assert property (p_fs) else $error("full scale wrong");
	property p_amp;
		amp_offset_milli != 4'sh8;
	endproperty
	a_amp: assert property (p_amp) else $error("offset out of range");
	property p_amp_upd;
		$changed(amp_offset_milli) |-> $rose(s_axi_bvalid);
	endproperty
	a_amp_upd: assert property (p_amp_upd) else $error("offset moved without a write");
	property p_bw;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_bw: assert property (p_bw) else $error("no write response");
	property p_rd;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_rd: assert property (p_rd) else $error("bad read answer");
	property p_rst;
		disable iff (1'b0) !resetn ##1 1'b1 |-> src_temp && ref_bandgap && !irq && !conv_busy
			&& fs_milli_vdd == 7'h0e && ts_kelvin_offset_en && ts_trim == 4'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	cover property ($fell(conv_busy));
	cover property (irq);
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind ats_adc_ctrl ats_adc_ctrl_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.*);

// *** tb/test_adc_temp_sensor_control.sv ***
`timescale 1ns/1ns
module test_adc_temp_sensor_control;
	import ats_pkg::*;
	localparam int CC = 12;
	logic              clk = 1'b0, resetn = 1'b0;
	logic [11:0]       s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata, rs = 32'h5;
	logic [3:0]        s_axi_wstrb = 4'hf, ts_trim;
	logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ts_kelvin_offset_en;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic              irq, conv_busy, src_temp, src_gnd, ref_bandgap, ref_vdd_third, ref_vdd_half;
	logic [1:0]        s_axi_bresp, s_axi_rresp, ts_range;
	logic [7:0]        raw_sample = 8'h0;
	logic [2:0]        src_pin_pos, src_pin_neg;
	logic [6:0]        fs_milli_vdd;
	logic signed [3:0] amp_offset_milli;
	int                n_fail = 0, checks = 0, cyc = 0;
	ats_adc_ctrl #(.CONV_CYCLES(CC)) u_ats_adc_ctrl (.*);
	always #25 clk = ~clk;
	// ----
	// helpers
	// ----
	function logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function logic [7:0] sat(input logic [7:0] a, o);
		int s;
		s = int'(a) + int'($signed(o));
		return s > 255 ? 8'hff : s < 0 ? 8'h00 : s[7:0];
	endfunction
	function logic [7:0] exp_src(input logic [2:0] s);
		case (s)
			3'h0: return 8'h80;
			3'h7: return 8'h40;
			3'h4: return 8'h0a;
			3'h5: return 8'h14;
			3'h6: return 8'h0c;
			default: return {2'h0, 3'h1 << (s - 3'h1), 3'h0};
		endcase
	endfunction
	task conclude();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] g, e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] i, d, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= {2'h0, i, 2'h0};
		s_axi_wdata <= {24'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask
	task rd(input logic [7:0] i, e, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= {2'h0, i, 2'h0};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, {24'h0, e});
		chk(s_axi_rresp, er);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			conclude();
		end
	end
	// ----
	// tests
	// ----
	initial begin
		logic [7:0] v, last;
		logic [31:0] r;
		int n;
		last = 8'h00;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		rd(ATS_IDX_CFG, 8'h00, 2'h0);
		rd(ATS_IDX_AOFFS, 8'h00, 2'h0);
		rd(ATS_IDX_TCAL, 8'h20, 2'h0);
		rd(ATS_IDX_TOFS, 8'h00, 2'h0);
		$display("reset test done");
		for (int k = 0; k < 16; k++) begin
			r = rnd();
			v = {1'b0, k[2:0], k[3:2], r[1:0]};
			wr(ATS_IDX_CFG, v, 2'h0);
			rd(ATS_IDX_CFG, v, 2'h0);
			chk({src_temp, src_gnd, src_pin_pos, src_pin_neg}, exp_src(v[6:4]));
			chk({ref_bandgap, ref_vdd_third, ref_vdd_half}, {!v[3], v[3:2] == 2'h2, &v[3:2]});
			chk(fs_milli_vdd, (v[2] ? 7'h15 : 7'h0e) * (v[1:0] + 32'h1));
			wr(ATS_IDX_AOFFS, r[15:8], 2'h0);
			rd(ATS_IDX_AOFFS, {4'h0, r[11:8]}, 2'h0);
			chk(amp_offset_milli, r[11] ? 32'h0 - r[10:8] : r[10:8]);
			wr(ATS_IDX_TCAL, r[23:16], 2'h0);
			rd(ATS_IDX_TCAL, r[23:16], 2'h0);
			chk({ts_range, ts_kelvin_offset_en, ts_trim}, {r[23:21], r[20] ? r[19:16] : 4'h0});
		end
		$display("field test done");
		wr(ATS_IDX_IRQ_EN, 8'h03, 2'h0);
		for (int k = 0; k < 6; k++) begin
			r = rnd();
			if (k < 2) r[15:0] = k ? 16'h0080 : 16'hff7f;
			wr(ATS_IDX_TOFS, r[7:0], 2'h0);
			raw_sample <= r[15:8];
			v = {1'b1, k[1] ? 3'h3 : 3'h0, r[19:16]};
			wr(ATS_IDX_CFG, v, 2'h0);
			rd(ATS_IDX_CFG, {1'b0, v[6:0]}, 2'h0);
			chk(conv_busy, 1'b1);
			rd(ATS_IDX_RESULT, last, 2'h0);
			n = 0;
			while (conv_busy && n < 100) begin
				@(posedge clk);
				n++;
			end
			rd(ATS_IDX_CFG, v, 2'h0);
			last = k[1] ? r[15:8] : sat(r[15:8], r[7:0]);
			rd(ATS_IDX_RESULT, last, 2'h0);
			chk(irq, 1'b1);
			rd(ATS_IDX_IRQ_ST, 8'h01, 2'h0);
			wr(ATS_IDX_IRQ_CL, 8'h03, 2'h0);
			rd(ATS_IDX_IRQ_ST, 8'h00, 2'h0);
			chk(irq, 1'b0);
		end
		$display("conversion test done");
		wr(ATS_IDX_IRQ_EN, 8'h00, 2'h0);
		wr(ATS_IDX_CFG, 8'h80, 2'h0);
		wr(ATS_IDX_CFG, 8'h80, 2'h0);
		n = 0;
		while (conv_busy && n < 100) begin
			@(posedge clk);
			n++;
		end
		rd(ATS_IDX_IRQ_ST, 8'h03, 2'h0);
		chk(irq, 1'b0);
		wr(ATS_IDX_IRQ_EN, 8'h02, 2'h0);
		rd(ATS_IDX_IRQ_ST, 8'h03, 2'h0);
		chk(irq, 1'b1);
		$display("irq test done");
		wr(ATS_IDX_RESULT, 8'h5a, 2'h0);
		rd(ATS_IDX_RESULT, sat(r[15:8], r[7:0]), 2'h0);
		wr(8'h30, 8'h11, 2'h2);
		rd(8'h30, 8'h00, 2'h2);
		$display("access test done");
		conclude();
	end
endmodule
